// ### pkg/instr_pkg.sv
// Package with register map, instruction fields and reset values of the indirect store unit.
package instr_pkg;

  // ==========================================================================
  // Register byte offsets on the AHB-Lite bus (word index = offset >> 2).
  localparam logic [7:0] OFS_WORK   = 8'h00;
  localparam logic [7:0] OFS_PTR0   = 8'h04;
  localparam logic [7:0] OFS_PTR1   = 8'h08;
  localparam logic [7:0] OFS_OPTION = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PCTRL  = 8'h14;
  localparam logic [7:0] OFS_INSTR  = 8'h18;
  localparam logic [7:0] OFS_IPORT0 = 8'h1c;
  localparam logic [7:0] OFS_IPORT1 = 8'h20;

  // ==========================================================================
  // Instruction word fields written to the instruction register.
  localparam int OPC_LSB  = 0;
  localparam int OPC_W    = 2;
  localparam int PSEL_BIT = 4;
  localparam int MODE_LSB = 5;
  localparam int REL_BIT  = 7;
  localparam int K_LSB    = 8;
  localparam int K_W      = 6;

  // Opcodes.
  localparam logic [1:0] OPC_NOP    = 2'h0;
  localparam logic [1:0] OPC_STORE  = 2'h1;
  localparam logic [1:0] OPC_OPTION = 2'h2;
  localparam logic [1:0] OPC_RESET  = 2'h3;

  // Addressing-mode field encodings.
  localparam logic [1:0] MODE_PREINC  = 2'h0;
  localparam logic [1:0] MODE_PREDEC  = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_POSTDEC = 2'h3;

  // ==========================================================================
  // Widths and reset values.
  localparam int         PTR_W      = 16;
  localparam logic [7:0] WORK_RST   = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam int         FLAG_BIT   = 0;

  // Read-path stages: address taken, memory addressed, data returned.
  typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_DATA} rd_stage_e;

endpackage

// ### rtl/data_ram.sv
// Data memory with one write port and one registered read port.
`timescale 1ns/100ps
module data_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock.
  input  wire logic          mclk_i,
  // Write port.
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read port.
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(2**AW)-1];

  // ==========================================================================
  // Storage has no reset; read data come out of a register, so a read costs a cycle.
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// ### rtl/indirect_store_unit.sv
// Indirect store, option load, no-operation and software reset execution with an AHB-Lite register port.
//
// Notes on behaviour
// - Store writes working value at selected pointer.
// - Mode field picks pre/post increment or decrement.
// - Relative form adds signed offset -32..31.
// - Pointer steps by one; relative form unchanged.
// - Indirect ports redirect to pointed memory.
// - Sixteen-bit pointer wraps modulo 65536.
// - Store and pointer step keep status flags.
// - Option load copies working value only.
// - Reset instruction resets device, clears flag.
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module indirect_store_unit
  import instr_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Core events.
  output logic             device_reset_o,
  output logic             instr_done_o
);
  import instr_pkg::*;

  // ==========================================================================
  // State.
  logic [7:0]       work_r;
  logic [PTR_W-1:0] ptr_r [2];
  logic [7:0]       option_r;
  logic [7:0]       status_r;
  logic             reset_instr_flag_n_r;
  logic [15:0]      instr_r;
  logic             soft_rst_r;
  logic             dph_wr_r;
  logic [7:0]       dph_ofs_r;
  rd_stage_e        rd_stage_r;
  logic [31:0]      rd_mux;
  logic [7:0]       mem_rdata;

  // ==========================================================================
  // Bus decode. Only whole-word transfers are supported, so hsize is not examined.
  wire       addr_ok   = hsel_i & htrans_i[1] & hready_i;
  wire       wr_accept = addr_ok & hwrite_i;
  wire       rd_accept = addr_ok & ~hwrite_i;
  wire [7:0] req_ofs   = {haddr_i[7:2], 2'b00};
  wire       hi_zero   = (haddr_i[31:8] == 24'h000000);
  wire       wr_instr  = dph_wr_r & (dph_ofs_r == OFS_INSTR);
  wire       wr_iport0 = dph_wr_r & (dph_ofs_r == OFS_IPORT0);
  wire       wr_iport1 = dph_wr_r & (dph_ofs_r == OFS_IPORT1);

  // ==========================================================================
  // Instruction decode, taken straight from the written word in its data phase.
  wire [1:0]       opc       = hwdata_i[OPC_LSB +: OPC_W];
  wire             psel      = hwdata_i[PSEL_BIT];
  wire [1:0]       mode      = hwdata_i[MODE_LSB +: 2];
  wire             rel       = hwdata_i[REL_BIT];
  wire [K_W-1:0]   k         = hwdata_i[K_LSB +: K_W];
  wire             exec_nop  = wr_instr & (opc == OPC_NOP);
  wire             exec_st   = wr_instr & (opc == OPC_STORE);
  wire             exec_opt  = wr_instr & (opc == OPC_OPTION);
  wire             exec_rst  = wr_instr & (opc == OPC_RESET);
  wire [PTR_W-1:0] sel_ptr   = ptr_r[psel];
  wire [PTR_W-1:0] ptr_inc   = sel_ptr + 16'h0001;
  wire [PTR_W-1:0] ptr_dec   = sel_ptr - 16'h0001;
  wire [PTR_W-1:0] k_ext     = {{(PTR_W-K_W){k[K_W-1]}}, k};
  wire             is_inc    = (mode == MODE_PREINC) | (mode == MODE_POSTINC);

  // Effective address of the store.
  logic [PTR_W-1:0] eff_addr;
  always_comb begin
    eff_addr = sel_ptr;
    if (rel) begin
      eff_addr = sel_ptr + k_ext;
    end else begin
      case (mode)
        MODE_PREINC:  eff_addr = ptr_inc;
        MODE_PREDEC:  eff_addr = ptr_dec;
        MODE_POSTINC: eff_addr = sel_ptr;
        MODE_POSTDEC: eff_addr = sel_ptr;
        default:      eff_addr = sel_ptr;
      endcase
    end
  end

  // Pointer value left behind by the store.
  wire [PTR_W-1:0] ptr_after = rel ? sel_ptr : (is_inc ? ptr_inc : ptr_dec);

  // ==========================================================================
  // Memory write port: a store instruction or a write through an indirect port.
  // The indirect ports hold no storage; their traffic goes to the pointed cell.
  wire              mem_we    = exec_st | wr_iport0 | wr_iport1;
  wire [MEM_AW-1:0] mem_waddr = exec_st   ? eff_addr[MEM_AW-1:0] :
                                wr_iport1 ? ptr_r[1][MEM_AW-1:0] : ptr_r[0][MEM_AW-1:0];
  wire [7:0]        mem_wdata = exec_st ? work_r : hwdata_i[7:0];
  wire              rd_port1  = (dph_ofs_r == OFS_IPORT1);
  wire [MEM_AW-1:0] mem_raddr = rd_port1 ? ptr_r[1][MEM_AW-1:0] : ptr_r[0][MEM_AW-1:0];

  data_ram #(
    .AW (MEM_AW),
    .DW (8)
  ) u_ram (
    .mclk_i  (mclk_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // ==========================================================================
  // Bus phase tracking. Reads take two wait states because memory data are registered.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      dph_wr_r    <= 1'b0;
      dph_ofs_r   <= 8'h00;
      rd_stage_r  <= RD_IDLE;
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h00000000;
      hresp_o     <= 1'b0;
    end else begin
      dph_wr_r <= wr_accept & hi_zero;
      hresp_o  <= 1'b0; // No access can fail, so only OKAY is ever returned.
      if (addr_ok) begin
        dph_ofs_r <= hi_zero ? req_ofs : 8'hfc;
      end
      case (rd_stage_r)
        RD_IDLE: begin
          if (rd_accept) begin
            rd_stage_r  <= RD_MEM;
            hreadyout_o <= 1'b0;
          end
        end
        RD_MEM:  rd_stage_r <= RD_DATA;
        RD_DATA: begin
          rd_stage_r  <= RD_IDLE;
          hrdata_o    <= rd_mux;
          hreadyout_o <= 1'b1;
        end
        default: rd_stage_r <= RD_IDLE;
      endcase
    end
  end

  // Read data selection; unmapped offsets read as zero.
  always_comb begin
    case (dph_ofs_r)
      OFS_WORK:   rd_mux = {24'h000000, work_r};
      OFS_PTR0:   rd_mux = {16'h0000, ptr_r[0]};
      OFS_PTR1:   rd_mux = {16'h0000, ptr_r[1]};
      OFS_OPTION: rd_mux = {24'h000000, option_r};
      OFS_STATUS: rd_mux = {24'h000000, status_r};
      OFS_PCTRL:  rd_mux = {31'h00000000, reset_instr_flag_n_r};
      OFS_INSTR:  rd_mux = {16'h0000, instr_r};
      OFS_IPORT0: rd_mux = {24'h000000, mem_rdata};
      OFS_IPORT1: rd_mux = {24'h000000, mem_rdata};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Core registers. A software reset returns them to their reset values one cycle
  // after the instruction, but leaves the reset-source flag cleared.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      work_r   <= WORK_RST;
      option_r <= OPTION_RST;
      status_r <= STATUS_RST;
      instr_r  <= 16'h0000;
    end else if (soft_rst_r) begin
      work_r   <= WORK_RST;
      option_r <= OPTION_RST;
      status_r <= STATUS_RST;
      instr_r  <= 16'h0000;
    end else if (dph_wr_r) begin
      if (dph_ofs_r == OFS_WORK) begin
        work_r <= hwdata_i[7:0];
      end
      if (dph_ofs_r == OFS_STATUS) begin
        status_r <= hwdata_i[7:0];
      end
      if (dph_ofs_r == OFS_OPTION || exec_opt) begin
        option_r <= hwdata_i[7:0];
      end
      if (exec_opt) begin
        option_r <= work_r;
      end
      if (wr_instr) begin
        instr_r <= hwdata_i[15:0];
      end
    end
  end

  // Pointers: one generate loop, each written by the bus or stepped by a store.
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        ptr_r[i] <= PTR_RST;
      end else if (soft_rst_r) begin
        ptr_r[i] <= PTR_RST;
      end else if (exec_st && psel == i) begin
        ptr_r[i] <= ptr_after;
      end else if (dph_wr_r && dph_ofs_r == (i == 0 ? OFS_PTR0 : OFS_PTR1)) begin
        ptr_r[i] <= hwdata_i[PTR_W-1:0];
      end
    end
  end

  // Reset-source flag: set by power-up reset and by software, cleared by the reset instruction.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reset_instr_flag_n_r <= 1'b1;
      soft_rst_r           <= 1'b0;
      device_reset_o       <= 1'b0;
      instr_done_o         <= 1'b0;
    end else begin
      soft_rst_r     <= exec_rst;
      device_reset_o <= exec_rst;
      instr_done_o   <= wr_instr;
      if (exec_rst) begin
        reset_instr_flag_n_r <= 1'b0;
      end else if (dph_wr_r && dph_ofs_r == OFS_PCTRL) begin
        reset_instr_flag_n_r <= hwdata_i[FLAG_BIT];
      end
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_flag_cleared;
    !reset_instr_flag_n_r && device_reset_o;
  endsequence
  sequence s_regs_restored;
    work_r == WORK_RST && option_r == OPTION_RST && ptr_r[0] == PTR_RST;
  endsequence

  a_store_writes_work: assert property (exec_st |-> mem_we && mem_wdata == work_r)
    else $error("Store did not write the working value.");
  a_mode_preinc_addr: assert property (exec_st && !rel && mode == MODE_PREINC
      |-> mem_waddr == MEM_AW'(sel_ptr + 16'h0001))
    else $error("Pre-increment address wrong.");
  a_mode_post_addr: assert property (exec_st && !rel && mode[1] |-> mem_waddr == sel_ptr[MEM_AW-1:0])
    else $error("Post-mode address wrong.");
  a_mode_predec_addr: assert property (exec_st && !rel && mode == MODE_PREDEC
      |-> mem_waddr == MEM_AW'(sel_ptr - 16'h0001))
    else $error("Pre-decrement address wrong.");
  a_rel_offset_addr: assert property (exec_st && rel
      |-> mem_waddr == MEM_AW'(sel_ptr + {{10{k[5]}}, k}))
    else $error("Relative address wrong.");
  a_ptr_inc_step: assert property (exec_st && !rel && is_inc && !psel
      |=> ptr_r[0] == $past(ptr_r[0]) + 16'h0001)
    else $error("Pointer not incremented.");
  a_ptr_dec_step: assert property (exec_st && !rel && !is_inc && psel
      |=> ptr_r[1] == $past(ptr_r[1]) - 16'h0001)
    else $error("Pointer not decremented.");
  a_rel_ptr_hold: assert property (exec_st && rel |=> $stable(ptr_r[0]) && $stable(ptr_r[1]))
    else $error("Relative form changed a pointer.");
  a_port_redirect: assert property (wr_iport1 |-> mem_we && mem_waddr == ptr_r[1][MEM_AW-1:0])
    else $error("Indirect port write not redirected.");
  a_ptr_wrap_low: assert property (exec_st && !rel && !is_inc && sel_ptr == 16'h0000 && psel
      |=> ptr_r[1] == 16'hffff)
    else $error("Pointer did not wrap below zero.");
  a_store_keeps_status: assert property (exec_st |=> $stable(status_r))
    else $error("Store changed the status flags.");
  a_option_load: assert property (exec_opt |=> option_r == $past(work_r) && $stable(work_r)
      && $stable(status_r))
    else $error("Option load wrong.");
  a_reset_flag_seq: assert property (exec_rst |=> s_flag_cleared ##1 s_regs_restored)
    else $error("Software reset sequence wrong.");
  a_nop_quiet: assert property (exec_nop |=> instr_done_o && $stable(work_r) && $stable(option_r)
      && $stable(status_r) && $stable(ptr_r[0]) && $stable(ptr_r[1]) && !mem_we)
    else $error("No-operation changed state.");

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the indirect store unit through its AHB-Lite port.
`timescale 1ns/100ps
module tb_top;
  import instr_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals.
  logic        mclk_i   = 1'b0;
  logic        reset_i  = 1'b1;
  logic        hsel_i   = 1'b0;
  logic [31:0] haddr_i  = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i  = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        device_reset_o;
  logic        instr_done_o;
  logic [31:0] rd;
  int          err_total       = 0;
  int          samples_checked = 0;
  int          done_cnt        = 0;
  int          rst_cnt         = 0;
  logic [15:0] ea_t [4] = '{16'h0041, 16'h003f, 16'h0040, 16'h0040};
  logic [15:0] ep_t [4] = '{16'h0041, 16'h003f, 16'h0041, 16'h003f};

  // With a single slave its ready output is the bus ready.
  indirect_store_unit indirect_store_unit_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .device_reset_o(device_reset_o), .instr_done_o(instr_done_o));

  // Clock of 4 ns.
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  // Pulses last one cycle, so they are counted at every edge rather than polled.
  always @(posedge mclk_i) begin
    if (instr_done_o === 1'b1) done_cnt++;
    if (device_reset_o === 1'b1) rst_cnt++;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single transfer; the address phase is held until ready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk("hresp", 32'h0, {31'h0, hresp_o});
  endtask

  function automatic logic [15:0] mk(input logic [1:0] opc, input logic ps, input logic [1:0] md,
                                     input logic rl, input logic [5:0] k);
    mk = 16'(opc) | (16'(ps) << PSEL_BIT) | (16'(md) << MODE_LSB) | (16'(rl) << REL_BIT) | (16'(k) << K_LSB);
  endfunction

  // Stores and then reads the cell back through the indirect port at the expected address.
  task automatic store_case(input logic ps, input logic [1:0] md, input logic rl, input logic [5:0] k,
                            input logic [15:0] p, input logic [7:0] w, input logic [15:0] ea,
                            input logic [15:0] ep);
    int         d0;
    logic [7:0] pa;
    pa = ps ? OFS_PTR1 : OFS_PTR0;
    d0 = done_cnt;
    bus(1'b1, OFS_STATUS, 32'h5a);
    bus(1'b1, OFS_WORK, {24'h0, w});
    bus(1'b1, pa, {16'h0, p});
    bus(1'b1, OFS_INSTR, {16'h0, mk(OPC_STORE, ps, md, rl, k)});
    bus(1'b0, pa, 32'h0);
    chk("pointer", {16'h0, ep}, rd);
    chk("done pulses", 32'(d0 + 1), 32'(done_cnt));
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h5a, rd);
    bus(1'b1, pa, {16'h0, ea});
    bus(1'b0, ps ? OFS_IPORT1 : OFS_IPORT0, 32'h0);
    chk("stored cell", {24'h0, w}, rd);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic test_modes;
    for (int m = 0; m < 4; m++) begin
      store_case(m[0], 2'(m), 1'b0, 6'h0, 16'h0040, 8'(8'h10 + m), ea_t[m], ep_t[m]);
    end
    store_case(1'b1, 2'h2, 1'b1, 6'h20, 16'h0050, 8'h77, 16'h0030, 16'h0050);
    store_case(1'b0, 2'h3, 1'b1, 6'h1f, 16'h0050, 8'h78, 16'h006f, 16'h0050);
    store_case(1'b0, 2'h0, 1'b0, 6'h0, 16'hffff, 8'h81, 16'h0000, 16'h0000);
    store_case(1'b1, 2'h3, 1'b0, 6'h0, 16'h0000, 8'h82, 16'h0000, 16'hffff);
    store_case(1'b0, 2'h1, 1'b0, 6'h0, 16'h0000, 8'h83, 16'hffff, 16'hffff);
    $display("test modes done");
  endtask

  // Both ports reach the same memory, so a write through one is read through the other.
  task automatic test_redirect;
    bus(1'b1, OFS_PTR0, 32'h0090);
    bus(1'b1, OFS_PTR1, 32'h0090);
    bus(1'b1, OFS_IPORT0, 32'h66);
    bus(1'b0, OFS_IPORT1, 32'h0);
    chk("port redirect", 32'h66, rd);
    bus(1'b0, OFS_PTR0, 32'h0);
    chk("pointer kept", 32'h0090, rd);
    $display("test redirect done");
  endtask

  task automatic test_option_nop;
    int d0;
    bus(1'b1, OFS_WORK, 32'h4f);
    bus(1'b1, OFS_INSTR, {16'h0, mk(OPC_OPTION, 1'b0, 2'h0, 1'b0, 6'h0)});
    bus(1'b0, OFS_OPTION, 32'h0);
    chk("option", 32'h4f, rd);
    bus(1'b0, OFS_WORK, 32'h0);
    chk("work kept", 32'h4f, rd);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status kept", 32'h5a, rd);
    d0 = done_cnt;
    bus(1'b1, OFS_WORK, 32'h21);
    bus(1'b1, OFS_INSTR, {16'h0, mk(OPC_NOP, 1'b1, 2'h2, 1'b0, 6'h0)});
    bus(1'b0, OFS_WORK, 32'h0);
    chk("nop work", 32'h21, rd);
    chk("nop done", 32'(d0 + 1), 32'(done_cnt));
    bus(1'b0, OFS_PTR1, 32'h0);
    chk("nop pointer", 32'h0090, rd);
    bus(1'b0, OFS_OPTION, 32'h0);
    chk("nop option", 32'h4f, rd);
    $display("test option and nop done");
  endtask

  // Flag reset value, then the software reset that leaves the flag cleared and restores the reset values.
  task automatic test_reset;
    bus(1'b0, OFS_PCTRL, 32'h0);
    chk("flag armed", 32'h1, rd);
    bus(1'b1, OFS_INSTR, {16'h0, mk(OPC_RESET, 1'b0, 2'h0, 1'b0, 6'h0)});
    repeat (3) @(posedge mclk_i);
    chk("reset pulses", 32'h1, 32'(rst_cnt));
    bus(1'b0, OFS_PCTRL, 32'h0);
    chk("flag cleared", 32'h0, rd);
    bus(1'b0, OFS_WORK, 32'h0);
    chk("work reset", {24'h0, WORK_RST}, rd);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", {24'h0, STATUS_RST}, rd);
    bus(1'b0, OFS_OPTION, 32'h0);
    chk("option reset", {24'h0, OPTION_RST}, rd);
    bus(1'b0, OFS_PTR1, 32'h0);
    chk("pointer reset", {16'h0, PTR_RST}, rd);
    bus(1'b1, 8'h40, 32'h12);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and a watchdog well beyond the few hundred cycles needed.
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    test_modes();
    test_redirect();
    test_option_nop();
    test_reset();
    give_verdict();
  end

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule
